// *** hdl/cst_defines.svh ***
// register offsets, field positions, reset values and timing for the sync/time config block
`ifndef CST_DEFINES_SVH
`define CST_DEFINES_SVH

// register byte offsets
`define CST_ADDR_SYNC_COBID 8'h00
`define CST_ADDR_TIME_COBID 8'h04
`define CST_ADDR_SYNC_PERIOD 8'h08
`define CST_ADDR_MODE 8'h0c
`define CST_ADDR_NODE_ID 8'h10
`define CST_ADDR_STATUS 8'h14

// reset values
`define CST_RST_SYNC_COBID 32'h0000_0080
`define CST_RST_TIME_COBID 32'h0000_0100
`define CST_RST_SYNC_PERIOD_MS 16'h0014
`define CST_RST_NODE_ID 7'h21
`define CST_RST_ALIGN 1'h1

// identifier word layout
`define CST_COB_APPLY_BIT 31
`define CST_COB_GEN_BIT 30
`define CST_COB_ZERO_HI 28
`define CST_COB_ZERO_LO 11
`define CST_COB_ID_HI 10

// mode register layout
`define CST_MODE_MASTER_LSB 0
`define CST_MODE_RATE_LSB 4
`define CST_MODE_ALIGN_BIT 8

// status register layout
`define CST_STAT_TIME_APPLY 0
`define CST_STAT_TIME_TX 1
`define CST_STAT_SYNC_GEN 2
`define CST_STAT_MASTER 3
`define CST_STAT_OPER 4
`define CST_STAT_SYNC_BAD 5
`define CST_STAT_TIME_BAD 6
`define CST_STAT_NODE_LSB 8

// timing
`define CST_CLK_HZ 20000000
`define CST_SYNC_STEP_MS 10
`define CST_SYNC_STEP_CYCLES (`CST_SYNC_STEP_MS * (`CST_CLK_HZ / 1000))
`define CST_NODE_ID_MIN 7'h01

`endif

// *** hdl/cst_pkg.sv ***
// types shared by the sync/time config block
package cst_pkg;

   // network management role
   typedef enum logic [1:0] {
      cst_master_off,
      cst_master_default,
      cst_master_on
   } cst_master_t;

   // selectable bit rates, slowest first
   typedef enum logic [2:0] {
      cst_rate_20k,
      cst_rate_50k,
      cst_rate_100k,
      cst_rate_125k,
      cst_rate_250k,
      cst_rate_500k,
      cst_rate_800k,
      cst_rate_1000k
   } cst_rate_t;

   // ahb-lite data phase tracking
   typedef enum logic [1:0] {
      cst_bus_idle,
      cst_bus_write,
      cst_bus_read
   } cst_bus_t;

endpackage

// *** hdl/cst_cobid_decode.sv ***
// splits one sync/time identifier word into its fields
`timescale 1ns/100ps
`include "cst_defines.svh"

module cst_cobid_decode (
   input wire logic [31:0] cob_word,
   output logic [10:0] can_id,
   output logic apply_flag,
   output logic gen_flag,
   output logic bad_word
);

   // bit 29 is ignored on purpose, only 28..11 must be zero
   assign can_id = cob_word[`CST_COB_ID_HI:0];
   assign apply_flag = cob_word[`CST_COB_APPLY_BIT];
   assign gen_flag = cob_word[`CST_COB_GEN_BIT];
   assign bad_word = |cob_word[`CST_COB_ZERO_HI:`CST_COB_ZERO_LO];

endmodule

// *** hdl/cst_sync_timer.sv ***
// periodic sync pulse in whole 10 ms steps
`timescale 1ns/100ps
`include "cst_defines.svh"

module cst_sync_timer #(
   parameter int STEP_CYCLES = `CST_SYNC_STEP_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic enable,
   input wire logic [15:0] period_ms,
   output logic sync_pulse
);

   logic [31:0] pre_cnt;
   logic [15:0] step_cnt;
   logic [15:0] steps;
   logic step_done;

   if (STEP_CYCLES < 1) begin : g_chk
      $error("STEP_CYCLES must be at least one");
   end

   // round the period up to the next step; zero means no sync
   assign steps = 16'((32'(period_ms) + 32'h9) / 32'ha);
   assign step_done = (pre_cnt == 32'(STEP_CYCLES - 1));

   // step prescaler restarts whenever the producer is off
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_cnt <= 32'h0;
      end else if (ce) begin
         if (!enable || step_done) begin
            pre_cnt <= 32'h0;
         end else begin
            pre_cnt <= pre_cnt + 32'h1;
         end
      end
   end

   // count steps and emit one-cycle pulse at the end of the period
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         step_cnt <= 16'h0;
         sync_pulse <= 1'b0;
      end else if (ce) begin
         sync_pulse <= 1'b0;
         if (!enable || steps == 16'h0) begin
            step_cnt <= 16'h0;
         end else if (step_done) begin
            if (step_cnt >= steps - 16'h1) begin
               step_cnt <= 16'h0;
               sync_pulse <= 1'b1;
            end else begin
               step_cnt <= step_cnt + 16'h1;
            end
         end
      end
   end

endmodule

// *** hdl/cst_config.sv ***
// can interface sync/time object config, master decision and node id select
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "cst_defines.svh"

module cst_config #(
   parameter int SYNC_STEP_CYCLES = `CST_SYNC_STEP_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [6:0] unit_number,
   input wire logic lowest_node_id,
   input wire logic start_remote_node,
   output logic [6:0] node_id,
   output logic [10:0] sync_cob_id,
   output logic [10:0] time_cob_id,
   output logic sync_pulse,
   output logic time_apply,
   output logic time_transmit,
   output logic [2:0] bit_rate_sel,
   output logic [10:0] bit_clks,
   output logic operational,
   output logic master_role
);

   // configuration registers
   logic [31:0] sync_cob;
   logic [31:0] time_cob;
   logic [15:0] sync_period_ms;
   cst_pkg::cst_master_t master_mode;
   cst_pkg::cst_rate_t rate;
   logic node_id_follows_unit_number;
   logic [6:0] node_id_cfg;

   // bus tracking
   cst_pkg::cst_bus_t bus_state;
   logic [7:0] addr_q;
   logic addr_ok_q;
   logic accept;
   logic addr_ok;
   logic [31:0] read_mux;

   // pin synchronisers
   logic [6:0] unit_meta;
   logic [6:0] unit_sync;
   logic lowest_meta;
   logic lowest_sync;

   // decoded objects, index 0 sync, index 1 time
   logic [31:0] cob_word [2];
   logic [10:0] cob_id [2];
   logic cob_apply [2];
   logic cob_gen [2];
   logic cob_bad [2];

   // next values of registered outputs
   logic next_apply;
   logic next_tx;
   logic next_master;
   logic [10:0] next_bit_clks;
   logic sync_pulse_raw;

   // address phase is taken whenever selected, ready and not idle/busy
   assign accept = hsel && hready && htrans[1];
   assign addr_ok = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'h0) && (haddr[4:0] <= 5'h14);

   // unit number and master hint are pins, two flops before use
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         unit_meta <= 7'h0;
         unit_sync <= 7'h0;
         lowest_meta <= 1'b0;
         lowest_sync <= 1'b0;
      end else if (ce) begin
         unit_meta <= unit_number;
         unit_sync <= unit_meta;
         lowest_meta <= lowest_node_id;
         lowest_sync <= lowest_meta;
      end
   end

   // ahb-lite data phase: writes complete with no wait, reads take one wait
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_state <= cst_pkg::cst_bus_idle;
         addr_q <= 8'h0;
         addr_ok_q <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= 32'h0;
         hresp <= 1'b0;
      end else if (ce) begin
         hresp <= 1'b0; // only okay responses, error never shows
         if (bus_state == cst_pkg::cst_bus_read) begin
            hrdata <= read_mux;
            hreadyout <= 1'b1;
            bus_state <= cst_pkg::cst_bus_idle;
         end else if (accept) begin
            addr_q <= haddr[7:0];
            addr_ok_q <= addr_ok;
            hreadyout <= hwrite;
            bus_state <= hwrite ? cst_pkg::cst_bus_write : cst_pkg::cst_bus_read;
         end else begin
            bus_state <= cst_pkg::cst_bus_idle;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_cob <= `CST_RST_SYNC_COBID;
         time_cob <= `CST_RST_TIME_COBID;
      end else if (ce && bus_state == cst_pkg::cst_bus_write && addr_ok_q) begin
         if (addr_q == `CST_ADDR_SYNC_COBID) begin
            sync_cob <= hwdata;
         end
         if (addr_q == `CST_ADDR_TIME_COBID) begin
            time_cob <= hwdata;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_period_ms <= `CST_RST_SYNC_PERIOD_MS;
      end else if (ce && bus_state == cst_pkg::cst_bus_write && addr_ok_q &&
                   addr_q == `CST_ADDR_SYNC_PERIOD) begin
         sync_period_ms <= hwdata[15:0];
      end
   end

   // mode register: master role, bit rate, alignment
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         master_mode <= cst_pkg::cst_master_default;
         rate <= cst_pkg::cst_rate_250k;
         node_id_follows_unit_number <= `CST_RST_ALIGN;
      end else if (ce && bus_state == cst_pkg::cst_bus_write && addr_ok_q && addr_q == `CST_ADDR_MODE) begin
         // code 3 names no role, so such a write keeps the old role
         if (hwdata[`CST_MODE_MASTER_LSB+:2] != 2'h3) begin
            master_mode <= cst_pkg::cst_master_t'(hwdata[`CST_MODE_MASTER_LSB+:2]);
         end
         rate <= cst_pkg::cst_rate_t'(hwdata[`CST_MODE_RATE_LSB+:3]);
         node_id_follows_unit_number <= hwdata[`CST_MODE_ALIGN_BIT];
      end
   end

   // node id write refused when zero, keeps the old value
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         node_id_cfg <= `CST_RST_NODE_ID;
      end else if (ce && bus_state == cst_pkg::cst_bus_write && addr_ok_q &&
                   addr_q == `CST_ADDR_NODE_ID && hwdata[6:0] >= `CST_NODE_ID_MIN) begin
         node_id_cfg <= hwdata[6:0];
      end
   end

   // field split, one decoder per object
   assign cob_word[0] = sync_cob;
   assign cob_word[1] = time_cob;
   for (genvar i = 0; i < 2; i++) begin : g_cob
      cst_cobid_decode u_dec (
         .cob_word(cob_word[i]),
         .can_id(cob_id[i]),
         .apply_flag(cob_apply[i]),
         .gen_flag(cob_gen[i]),
         .bad_word(cob_bad[i])
      );
   end

   // master role: always in on mode, by lowest id in default mode
   always_comb begin
      next_master = 1'b0;
      unique case (master_mode)
         cst_pkg::cst_master_on: next_master = 1'b1;
         cst_pkg::cst_master_default: next_master = lowest_sync;
         cst_pkg::cst_master_off: next_master = 1'b0;
      endcase
   end

   // time apply/transmit decision per master mode
   always_comb begin
      next_apply = 1'b0;
      next_tx = 1'b0;
      unique case (master_mode)
         cst_pkg::cst_master_off: begin
            next_apply = cob_apply[1] | cob_gen[1];
            next_tx = cob_apply[1] & cob_gen[1];
         end
         // default mode, apply set needs master role to send
         cst_pkg::cst_master_default: begin
            next_apply = cob_apply[1];
            next_tx = cob_gen[1] & (~cob_apply[1] | lowest_sync);
         end
         cst_pkg::cst_master_on: begin
            next_apply = cob_apply[1];
            next_tx = cob_gen[1];
         end
      endcase
   end

   // bit time in core clocks for the selected rate
   always_comb begin
      unique case (rate)
         cst_pkg::cst_rate_20k: next_bit_clks = 11'(`CST_CLK_HZ / 20000);
         cst_pkg::cst_rate_50k: next_bit_clks = 11'(`CST_CLK_HZ / 50000);
         cst_pkg::cst_rate_100k: next_bit_clks = 11'(`CST_CLK_HZ / 100000);
         cst_pkg::cst_rate_125k: next_bit_clks = 11'(`CST_CLK_HZ / 125000);
         cst_pkg::cst_rate_250k: next_bit_clks = 11'(`CST_CLK_HZ / 250000);
         cst_pkg::cst_rate_500k: next_bit_clks = 11'(`CST_CLK_HZ / 500000);
         cst_pkg::cst_rate_800k: next_bit_clks = 11'(`CST_CLK_HZ / 800000);
         cst_pkg::cst_rate_1000k: next_bit_clks = 11'(`CST_CLK_HZ / 1000000);
      endcase
   end

   // operational state, only off mode needs the remote start
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         operational <= 1'b0;
      end else if (ce && !operational) begin
         operational <= (master_mode != cst_pkg::cst_master_off) || start_remote_node;
      end
   end

   // sync producer runs only when generating and operational
   cst_sync_timer #(
      .STEP_CYCLES(SYNC_STEP_CYCLES)
   ) u_sync_timer (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .ce(ce),
      .enable(cob_gen[0] && operational),
      .period_ms(sync_period_ms),
      .sync_pulse(sync_pulse_raw)
   );

   // sync pulse leaves through a flop; timer output already clean
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_pulse <= 1'b0;
      end else if (ce) begin
         sync_pulse <= sync_pulse_raw;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         time_apply <= 1'b0;
         time_transmit <= 1'b0;
         master_role <= 1'b0;
         sync_cob_id <= 11'h0;
         time_cob_id <= 11'h0;
      end else if (ce) begin
         time_apply <= next_apply;
         time_transmit <= next_tx;
         master_role <= next_master;
         sync_cob_id <= cob_id[0];
         time_cob_id <= cob_id[1];
      end
   end

   // node id follows the unit number while alignment is on
   // all nodes share the rate; the block only presents it
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         node_id <= 7'h0;
         bit_rate_sel <= 3'h0;
         bit_clks <= 11'h0;
      end else if (ce) begin
         node_id <= node_id_follows_unit_number ? unit_sync : node_id_cfg;
         bit_rate_sel <= rate;
         bit_clks <= next_bit_clks;
      end
   end

   // read mux; node id register hides its setting while aligned
   always_comb begin
      read_mux = 32'h0;
      if (addr_ok_q) begin
         unique case (addr_q)
            `CST_ADDR_SYNC_COBID: read_mux = sync_cob;
            `CST_ADDR_TIME_COBID: read_mux = time_cob;
            `CST_ADDR_SYNC_PERIOD: read_mux = {16'h0, sync_period_ms};
            `CST_ADDR_MODE: begin
               read_mux[`CST_MODE_MASTER_LSB+:2] = master_mode;
               read_mux[`CST_MODE_RATE_LSB+:3] = rate;
               read_mux[`CST_MODE_ALIGN_BIT] = node_id_follows_unit_number;
            end
            `CST_ADDR_NODE_ID: read_mux = node_id_follows_unit_number ? 32'h0 : {25'h0, node_id_cfg};
            `CST_ADDR_STATUS: begin
               read_mux[`CST_STAT_TIME_APPLY] = time_apply;
               read_mux[`CST_STAT_TIME_TX] = time_transmit;
               read_mux[`CST_STAT_SYNC_GEN] = cob_gen[0] && operational;
               read_mux[`CST_STAT_MASTER] = master_role;
               read_mux[`CST_STAT_OPER] = operational;
               read_mux[`CST_STAT_SYNC_BAD] = cob_bad[0];
               read_mux[`CST_STAT_TIME_BAD] = cob_bad[1];
               read_mux[`CST_STAT_NODE_LSB+:7] = node_id;
            end
            default: read_mux = 32'h0;
         endcase
      end
   end

   // hsize unused: every access is treated as a whole word
   logic unused_ok;
   assign unused_ok = ^hsize;

endmodule

// *** testbench/cst_config_asserts.sv ***
// concurrent checks on the ports of the sync/time config block
`timescale 1ns/100ps
module cst_config_asserts #(
   parameter int SYNC_STEP_CYCLES = 200000
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic sync_pulse,
   input wire logic [2:0] bit_rate_sel,
   input wire logic [10:0] bit_clks,
   input wire logic operational,
   input wire logic master_role
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   logic [31:0] gap;

   // cycles since the last sync pulse, saturating so reset never looks like a short gap
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         gap <= 32'hffff_ffff;
      end else if (sync_pulse) begin
         gap <= 32'h0;
      end else if (gap != 32'hffff_ffff) begin
         gap <= gap + 32'h1;
      end
   end

   function automatic logic [10:0] clks_for(input logic [2:0] s);
      logic [10:0] t [8] = '{11'h3e8, 11'h190, 11'hc8, 11'ha0, 11'h50, 11'h28, 11'h19, 11'h14};
      return t[s];
   endfunction

   sequence rd_taken;
      hsel && hready && htrans[1] && ce && !hwrite;
   endsequence
   sequence wr_taken;
      hsel && hready && htrans[1] && ce && hwrite;
   endsequence
   sequence bad_rd;
      rd_taken ##0 (haddr > 32'h14 || haddr[1:0] != 2'h0);
   endsequence
   sequence one_wait;
      !hreadyout ##1 hreadyout;
   endsequence

   read_wait_state_a: assert property (rd_taken |=> one_wait) // bus
      else $error("read did not take exactly one wait state");
   write_no_wait_a: assert property (wr_taken |=> hreadyout) // bus
      else $error("write data phase was stretched");
   bus_okay_a: assert property (hresp == 1'b0) // bus
      else $error("slave response not okay");
   unmapped_zero_a: assert property (bad_rd |-> ##2 hrdata == 32'h0) // bus
      else $error("unmapped read returned nonzero data");
   rate_clks_a: assert property (bit_clks != 11'h0 |-> bit_clks == clks_for(bit_rate_sel))
      else $error("bit length does not match selected rate");
   sync_single_a: assert property (sync_pulse |=> !sync_pulse)
      else $error("sync pulse longer than one cycle");
   sync_oper_a: assert property (sync_pulse |-> operational)
      else $error("sync produced while not operational");
   sync_gap_a: assert property (sync_pulse |-> gap >= 32'(SYNC_STEP_CYCLES - 1))
      else $error("sync pulses closer than one step");
   oper_sticky_a: assert property (operational |=> operational)
      else $error("operational state dropped");
   master_oper_a: assert property ($rose(master_role) |-> ##[0:2] operational)
      else $error("master role without operational state");
endmodule

bind cst_config cst_config_asserts #(.SYNC_STEP_CYCLES(SYNC_STEP_CYCLES)) u_chk (.core_clk(core_clk),
   .rst_b(rst_b), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sync_pulse(sync_pulse), .bit_rate_sel(bit_rate_sel),
   .bit_clks(bit_clks), .operational(operational), .master_role(master_role));

// *** testbench/cst_peer_node.sv ***
// behavioural model of another node on the can bus
`timescale 1ns/100ps
module cst_peer_node #(
   parameter int RETRY_CYCLES = 40
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic operational,
   input wire logic [2:0] bit_rate_sel,
   input wire logic [2:0] node_rate,
   input wire logic send_start,
   input wire logic want_lowest,
   output logic start_remote_node,
   output logic lowest_node_id,
   output logic rate_match
);
   logic waiting;
   int wait_cnt;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         start_remote_node <= 1'b0;
         waiting <= 1'b0;
         wait_cnt <= 0;
      end else begin
         start_remote_node <= 1'b0;
         if (send_start && !waiting) begin
            start_remote_node <= 1'b1;
            waiting <= 1'b1;
            wait_cnt <= 0;
         end else if (waiting && operational) begin
            waiting <= 1'b0;
         end else if (waiting && wait_cnt == RETRY_CYCLES) begin
            start_remote_node <= 1'b1; // no reply in time, ask again
            wait_cnt <= 0;
         end else if (waiting) begin
            wait_cnt <= wait_cnt + 1;
         end
      end
   end

   // arbitration outcome among default masters
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         lowest_node_id <= 1'b0;
      end else begin
         lowest_node_id <= want_lowest;
      end
   end

   assign rate_match = (node_rate === bit_rate_sel);
endmodule

// *** testbench/can_sync_time_cob_config_tb.sv ***
// self-checking bench for the sync/time config block
`timescale 1ns/100ps
module can_sync_time_cob_config_tb;
   localparam int STEP = 10;
   logic core_clk, rst_b, ce, hsel, hwrite, send_start, want_lowest;
   logic [31:0] haddr, hwdata, hrdata, rd, w;
   logic [1:0] htrans;
   logic [2:0] hsize, bit_rate_sel, node_rate;
   logic [6:0] unit_number, node_id;
   logic [10:0] sync_cob_id, time_cob_id, bit_clks;
   logic hreadyout, hresp, start_remote_node, lowest_node_id, sync_pulse, time_apply, time_transmit;
   logic operational, master_role, rate_match;
   wire logic hready;
   int error_cnt, n_compared, seed, n, p;
   logic [31:0] ra [7] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h18, 32'h2};
   logic [31:0] rv [7] = '{32'h80, 32'h100, 32'h14, 32'h141, 32'h0, 32'h0, 32'h0};
   logic [10:0] clk_tab [8] = '{11'h3e8, 11'h190, 11'hc8, 11'ha0, 11'h50, 11'h28, 11'h19, 11'h14};

   assign hready = hreadyout; // single slave drives the bus ready

   cst_config #(.SYNC_STEP_CYCLES(STEP)) uut (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .unit_number(unit_number),
      .lowest_node_id(lowest_node_id), .start_remote_node(start_remote_node), .node_id(node_id),
      .sync_cob_id(sync_cob_id), .time_cob_id(time_cob_id), .sync_pulse(sync_pulse), .time_apply(time_apply),
      .time_transmit(time_transmit), .bit_rate_sel(bit_rate_sel), .bit_clks(bit_clks),
      .operational(operational), .master_role(master_role));

   cst_peer_node peer (.core_clk(core_clk), .rst_b(rst_b), .operational(operational),
      .bit_rate_sel(bit_rate_sel), .node_rate(node_rate), .send_start(send_start), .want_lowest(want_lowest),
      .start_remote_node(start_remote_node), .lowest_node_id(lowest_node_id), .rate_match(rate_match));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // expected {master, apply, transmit} for a mode, time word flags and arbitration result
   function automatic logic [2:0] exp_time(input int m, input logic b31, input logic b30, input logic low);
      if (m == 0) return {1'b0, b30 | b31, b30 & b31};
      if (m == 1) return {low, b31, b30 & (~b31 | low)};
      return {1'b1, b31, b30};
   endfunction

   // sync spacing rounds the period up to whole steps
   function automatic int exp_gap(input int ms);
      return ((ms + 9) / 10) * STEP;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one single transfer; waits on ready without a bound, the watchdog ends a hang
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdv);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      do @(posedge core_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hready !== 1'b1);
      rdv = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic chk_reg(input string nm, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(nm, e, x);
   endtask

   task automatic settle;
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   task automatic next_pulse(output int k);
      k = 0;
      do begin
         @(negedge core_clk);
         k++;
      end while (sync_pulse !== 1'b1 && k < 1000);
   endtask

   task automatic complete_run;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // watchdog sized well above the expected run length
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      complete_run;
   end

   initial begin
      seed = 99806;
      error_cnt = 0;
      n_compared = 0;
      {ce, hsel, hwrite, send_start, want_lowest, rst_b} = 6'h20;
      {haddr, hwdata, htrans, hsize, node_rate} = {64'h0, 2'h0, 3'h2, 3'h4};
      unit_number = 7'($random(seed)) | 7'h01;
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      settle;
      chk("bit_rate_sel", 32'h4, 32'(bit_rate_sel));
      chk("bit_clks", 32'h50, 32'(bit_clks));
      chk("node_id", 32'(unit_number), 32'(node_id));
      for (int i = 0; i < 7; i++) chk_reg("reset_reg", ra[i], rv[i]);
      chk("operational", 32'h1, 32'(operational));
      @(posedge core_clk);
      send_start <= 1'b1;
      @(posedge core_clk);
      send_start <= 1'b0;
      settle;
      chk("operational", 32'h1, 32'(operational));
      // every mode, flag pair and arbitration
      for (int m = 0; m < 3; m++) for (int b = 0; b < 4; b++) for (int l = 0; l < 2; l++) begin
         w = $random(seed);
         w[28:11] = 18'h0;
         w[31:30] = 2'(b);
         wr(32'h4, w);
         want_lowest <= l[0];
         wr(32'hc, 32'h140 | 32'(m));
         settle;
         rd = {29'h0, master_role, time_apply, time_transmit};
         chk("time_flags", 32'(exp_time(m, w[31], w[30], l[0])), rd);
         chk("time_cob_id", 32'(w[10:0]), 32'(time_cob_id));
      end
      wr(32'h4, 32'h0008_0123);
      bus(1'b0, 32'h14, 32'h0, rd);
      chk("time_word_bad", 32'h1, 32'(rd[6]));
      for (int r = 0; r < 8; r++) begin
         wr(32'hc, 32'h101 | 32'(r << 4));
         node_rate <= 3'(r);
         settle;
         chk("bit_rate_sel", 32'(r), 32'(bit_rate_sel));
         chk("bit_clks", 32'(clk_tab[r]), 32'(bit_clks));
         chk("rate_match", 32'h1, 32'(rate_match));
      end
      // own node id, zero refused, alignment
      wr(32'hc, 32'h041);
      wr(32'h10, 32'h5);
      wr(32'h10, 32'h0);
      settle;
      chk("node_id", 32'h5, 32'(node_id));
      wr(32'h10, 32'h7f);
      chk_reg("node_reg", 32'h10, 32'h7f);
      settle;
      chk("node_id", 32'h7f, 32'(node_id));
      wr(32'hc, 32'h141);
      settle;
      chk("node_id", 32'(unit_number), 32'(node_id));
      // clock enable low freezes the bus, so the write is lost
      @(posedge core_clk);
      ce <= 1'b0;
      wr(32'hc, 32'h171);
      settle;
      chk("ce_frozen", 32'h4, 32'(bit_rate_sel));
      @(posedge core_clk);
      ce <= 1'b1;
      // step boundaries and a random period
      w = $random(seed);
      wr(32'h0, 32'h4000_0000 | (w & 32'h7ff));
      for (int j = 0; j < 4; j++) begin
         p = (j == 0) ? 1 : (j == 1) ? 10 : (j == 2) ? 11 : 1 + ($random(seed) & 32'h1f);
         wr(32'h8, 32'(p));
         next_pulse(n);
         next_pulse(n);
         next_pulse(n);
         chk("sync_gap", 32'(exp_gap(p)), 32'(n));
      end
      chk("sync_cob_id", w & 32'h7ff, 32'(sync_cob_id));
      wr(32'h0, 32'h80);
      settle;
      next_pulse(n);
      chk("sync_off", 32'h3e8, 32'(n));
      complete_run;
   end
endmodule
